// [mla_pkg.sv]
// Constants shared by the macrocell logic array: sizes, signal order, fields and the register map.
package mla_pkg;

	// ==========================================================================
	// Array dimensions
	localparam int NUM_DED = 10;
	localparam int NUM_PIN = 10;
	localparam int NUM_BUR = 8;
	localparam int NUM_CELL = 18;
	localparam int NUM_SIG = 39;
	localparam int NUM_LIT = 78;
	localparam int NUM_PT = 75;
	localparam int NUM_SUM_PT = 64;
	localparam int NUM_ST = 36;
	localparam int CFG_W = 68;
	localparam int SIG_W = 72;

	// ==========================================================================
	// Special product terms and sum term split
	localparam int PT_CLEAR = 64;
	localparam int PT_OE_BASE = 65;
	localparam int ST_ENABLE_BASE = 18;

	// ==========================================================================
	// Array input signal order, each expanded to a true and a complement literal
	localparam int SIG_DED_BASE = 0;
	localparam int SIG_PININ_BASE = 10;
	localparam int SIG_BUR_BASE = 20;
	localparam int SIG_PINFB_BASE = 28;
	localparam int SIG_INPUT_CAPTURE_CLOCK = 38;

	// ==========================================================================
	// Cell numbering: buried cells 0..7 are cells 0..7, pin cells 14..23 are cells 8..17
	localparam int BUR_NUM_FIRST = 0;
	localparam int PIN_NUM_FIRST = 14;
	localparam int PIN_CELL_BASE = 8;

	// ==========================================================================
	// Configuration word fields
	localparam int CFG_DPOL_LSB = 0;
	localparam int CFG_EPOL_LSB = 10;
	localparam int CFG_CKS_LSB = 28;
	localparam int CFG_BYP_LSB = 46;
	localparam int CFG_DED_LATCH = 64;
	localparam int CFG_DED_SYNC = 65;
	localparam int CFG_PIN_LATCH = 66;
	localparam int CFG_PIN_SYNC = 67;
	localparam logic [67:0] CFG_RESET = 68'hF_FFFF_C000_0000_0000;
	localparam logic [71:0] SIG_RESET = 72'h00_0000_0000_0000_0000;

	// ==========================================================================
	// APB register map, byte addresses
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_CFG0 = 12'h000;
	localparam logic [11:0] ADDR_CFG1 = 12'h004;
	localparam logic [11:0] ADDR_CFG2 = 12'h008;
	localparam logic [11:0] ADDR_SIG0 = 12'h00C;
	localparam logic [11:0] ADDR_SIG1 = 12'h010;
	localparam logic [11:0] ADDR_SIG2 = 12'h014;
	localparam logic [11:0] ADDR_STAT0 = 12'h018;
	localparam logic [11:0] ADDR_STAT1 = 12'h01C;
	localparam logic [1:0] OR_REGION = 2'h1;
	localparam int AND_WORDS = 3;
	localparam int OR_WORDS = 2;

endpackage

// [mla_core.sv]
// Macrocell logic array: input cells, product and sum arrays, output and state cells, APB slave.
//
// Contract
// - Each input section (dedicated, pin) is configured as one group, never per cell.
// - Capture clock enables latched cells while high, clocks registered cells on rise.
// - Section sync-select 1 makes it asynchronous; 0 gives it latch or register storage.
// - With storage, latch-select 1 means edge register, 0 means transparent latch.
// - Every output and state cell has its own enable polarity, clock-select and bypass bits; pin cells add a data polarity bit.
// - Clock-select 1, bypass 0: shared output clock with enable sum term as enable.
// - Clock-select 0, bypass 0: register clocked directly by its enable sum term.
// - Clock-select 0, bypass 1: data sum term passes combinationally; buried one feeds the array uninverted. The code instead registers it on every reference clock.
// - Pin cells have data polarity; buried cells need none, both forms feed the array.
// - Each enable sum term polarity follows that cell's enable polarity bit.
// - Clear product term resets all non-bypassed cell registers to zero together, on the next reference clock.
// - Pins use inverting buffers, so a cleared register shows one on an enabled pin with data polarity 0.
// - Each of ten pins has its own enable product term; inactive means high impedance.
// - Pin cells feed back before the buffer and through the pin input cell.
// - 75 product terms from 78 literals: true and complement of 39 signals.
// - Terms 0-63 feed sums, term 64 is clear, terms 65-74 are pin enables.
// - 64 terms make 36 sums: 18 data and 18 enable, one each per cell.
// - All cell and input-section configuration lives in one 68-bit configuration word; the AND and OR arrays have their own memories.
// - The 72-bit signature store is always readable.
// - Pin cells are numbered 14 to 23, buried cells 0 to 7.
module mla_core (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [mla_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [mla_pkg::NUM_DED-1:0] i_ded_in,
	input wire logic i_input_capture_clock,
	input wire logic i_output_register_clock,
	input wire logic [mla_pkg::NUM_PIN-1:0] i_pin_in,
	output logic [mla_pkg::NUM_PIN-1:0] o_pin_out,
	output logic [mla_pkg::NUM_PIN-1:0] o_pin_oe
);
	import mla_pkg::*;

	// ==========================================================================
	// Reset release
	logic rst_meta_reg;
	logic rst_n_reg;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// ==========================================================================
	// Pin synchronisers and glitch filter
	// A level only counts once the second and third stages agree, so a pin that
	// settles late costs one more cycle instead of a false edge.
	localparam int NSYNC = NUM_DED + NUM_PIN + 2;
	logic [NSYNC-1:0] sync_raw;
	logic [NSYNC-1:0] s1_reg;
	logic [NSYNC-1:0] s2_reg;
	logic [NSYNC-1:0] s3_reg;
	logic [NSYNC-1:0] filt_reg;

	assign sync_raw = {i_output_register_clock, i_input_capture_clock, i_pin_in, i_ded_in};

	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			filt_reg <= '0;
		end else begin
			s1_reg <= sync_raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
		end
	end

	logic input_capture_clock_lvl;
	logic output_register_clock_lvl;
	logic input_capture_clock_prev_reg;
	logic output_register_clock_prev_reg;
	logic input_capture_clock_rise;
	logic output_register_clock_rise;

	assign input_capture_clock_lvl = filt_reg[NUM_DED + NUM_PIN];
	assign output_register_clock_lvl = filt_reg[NUM_DED + NUM_PIN + 1];
	assign input_capture_clock_rise = input_capture_clock_lvl & ~input_capture_clock_prev_reg;
	assign output_register_clock_rise = output_register_clock_lvl & ~output_register_clock_prev_reg;

	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			input_capture_clock_prev_reg <= 1'b0;
			output_register_clock_prev_reg <= 1'b0;
		end else begin
			input_capture_clock_prev_reg <= input_capture_clock_lvl;
			output_register_clock_prev_reg <= output_register_clock_lvl;
		end
	end

	// ==========================================================================
	// Configuration and signature storage
	logic [CFG_W-1:0] cfg_reg;
	logic [SIG_W-1:0] sig_reg;
	logic [NUM_LIT-1:0] and_mem [NUM_PT];
	logic [NUM_SUM_PT-1:0] or_mem [NUM_ST];

	// ==========================================================================
	// Input cells, two sections of ten
	logic [NUM_DED+NUM_PIN-1:0] in_cell;
	logic [1:0] grp_sync;
	logic [1:0] grp_latch;

	assign grp_sync = {cfg_reg[CFG_PIN_SYNC], cfg_reg[CFG_DED_SYNC]};
	assign grp_latch = {cfg_reg[CFG_PIN_LATCH], cfg_reg[CFG_DED_LATCH]};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_DED + NUM_PIN; gi++) begin : g_in
			localparam int GRP = (gi < NUM_DED) ? 0 : 1;
			logic store_reg;
			logic take;

			// Registered cells take the capture clock rise, latched ones follow while high.
			assign take = grp_latch[GRP] ? input_capture_clock_rise : input_capture_clock_lvl;

			always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
				if (!rst_n_reg) begin
					store_reg <= 1'b0;
				end else if (!grp_sync[GRP] && take) begin
					store_reg <= filt_reg[gi];
				end
			end

			always_comb begin
				if (grp_sync[GRP]) begin
					in_cell[gi] = filt_reg[gi];
				end else if (!grp_latch[GRP] && input_capture_clock_lvl) begin
					in_cell[gi] = filt_reg[gi];
				end else begin
					in_cell[gi] = store_reg;
				end
			end
		end
	endgenerate

	// ==========================================================================
	// Product and sum arrays
	logic [NUM_CELL-1:0] cell_q;
	logic [NUM_SIG-1:0] sig_vec;
	logic [NUM_LIT-1:0] lit;
	logic [NUM_PT-1:0] pt;
	logic [NUM_ST-1:0] st;

	// Pin cells feed back from their own register; the pin path enters through the
	// pin input cells, so an input-mode pin turns its cell into a buried one.
	assign sig_vec = {input_capture_clock_lvl, cell_q[NUM_CELL-1:PIN_CELL_BASE], cell_q[NUM_BUR-1:0],
		in_cell};

	genvar gs;
	generate
		for (gs = 0; gs < NUM_SIG; gs++) begin : g_lit
			assign lit[2*gs] = sig_vec[gs];
			assign lit[2*gs+1] = ~sig_vec[gs];
		end
		// A term with no literal connected stays inactive, so an empty array drives nothing.
		for (gs = 0; gs < NUM_PT; gs++) begin : g_pt
			assign pt[gs] = (|and_mem[gs]) & (&(lit | ~and_mem[gs]));
		end
		for (gs = 0; gs < NUM_ST; gs++) begin : g_st
			assign st[gs] = |(or_mem[gs] & pt[NUM_SUM_PT-1:0]);
		end
	endgenerate

	// ==========================================================================
	// Output and state cells
	// Combinational cells are also sampled every cycle; this breaks the array loop
	// at the price of one cycle of feedback latency.
	genvar gc;
	generate
		for (gc = 0; gc < NUM_CELL; gc++) begin : g_cell
			logic d;
			logic e;
			logic clock_source_select;
			logic byp;
			logic e_prev_reg;
			logic q_reg;
			logic load;

			assign d = st[gc];
			assign e = st[ST_ENABLE_BASE + gc] ^ cfg_reg[CFG_EPOL_LSB + gc];
			assign clock_source_select = cfg_reg[CFG_CKS_LSB + gc];
			assign byp = cfg_reg[CFG_BYP_LSB + gc];
			assign load = clock_source_select ? (output_register_clock_rise & e) : (e & ~e_prev_reg);

			always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
				if (!rst_n_reg) begin
					e_prev_reg <= 1'b0;
				end else begin
					e_prev_reg <= e;
				end
			end

			always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
				if (!rst_n_reg) begin
					q_reg <= 1'b0;
				end else if (byp) begin
					q_reg <= d;
				end else if (pt[PT_CLEAR]) begin
					q_reg <= 1'b0;
				end else if (load) begin
					q_reg <= d;
				end
			end

			assign cell_q[gc] = q_reg;
		end
	endgenerate

	// ==========================================================================
	// Pin drivers, pin k is cell number PIN_NUM_FIRST + k
	logic [NUM_PIN-1:0] pin_out_next;

	assign pin_out_next = ~(cell_q[NUM_CELL-1:PIN_CELL_BASE] ^
		cfg_reg[CFG_DPOL_LSB +: NUM_PIN]);

	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_pin_out <= '0;
			o_pin_oe <= '0;
		end else begin
			o_pin_out <= pin_out_next;
			o_pin_oe <= pt[PT_OE_BASE +: NUM_PIN];
		end
	end

	// ==========================================================================
	// APB decode
	logic setup;
	logic hit;
	logic [31:0] rd_word;
	logic [6:0] pt_idx;
	logic [1:0] and_w;
	logic [5:0] st_idx;
	logic or_w;
	logic and_hit;
	logic or_hit;
	logic wr_fire;

	assign setup = i_psel & ~i_penable;
	assign pt_idx = i_paddr[10:4];
	assign and_w = i_paddr[3:2];
	assign st_idx = i_paddr[8:3];
	assign or_w = i_paddr[2];
	assign and_hit = i_paddr[11] && (pt_idx < 7'(NUM_PT)) && (and_w < 2'(AND_WORDS)) &&
		(i_paddr[1:0] == 2'h0);
	assign or_hit = (i_paddr[11:10] == OR_REGION) && !i_paddr[9] &&
		(st_idx < 6'(NUM_ST)) && (i_paddr[1:0] == 2'h0);

	always_comb begin
		rd_word = 32'h0000_0000;
		hit = 1'b1;
		if (and_hit) begin
			case (and_w)
				2'h0: rd_word = and_mem[pt_idx][31:0];
				2'h1: rd_word = and_mem[pt_idx][63:32];
				default: rd_word = {18'h0_0000, and_mem[pt_idx][77:64]};
			endcase
		end else if (or_hit) begin
			rd_word = or_w ? or_mem[st_idx][63:32] : or_mem[st_idx][31:0];
		end else begin
			case (i_paddr)
				ADDR_CFG0: rd_word = cfg_reg[31:0];
				ADDR_CFG1: rd_word = cfg_reg[63:32];
				ADDR_CFG2: rd_word = {28'h000_0000, cfg_reg[67:64]};
				ADDR_SIG0: rd_word = sig_reg[31:0];
				ADDR_SIG1: rd_word = sig_reg[63:32];
				ADDR_SIG2: rd_word = {24'h00_0000, sig_reg[71:64]};
				ADDR_STAT0: rd_word = {13'h0000, pt[PT_CLEAR], cell_q};
				ADDR_STAT1: rd_word = {2'h0, in_cell, pt[PT_OE_BASE +: NUM_PIN]};
				default: hit = 1'b0;
			endcase
		end
	end

	// Zero wait states: the answer is prepared in the setup cycle and presented at once.
	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end else begin
			o_pready <= setup;
			o_pslverr <= setup & ~hit;
			if (setup) begin
				o_prdata <= i_pwrite ? 32'h0000_0000 : rd_word;
			end
		end
	end

	assign wr_fire = i_psel & i_penable & o_pready & i_pwrite & hit;

	// ==========================================================================
	// Register writes
	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			cfg_reg <= CFG_RESET;
			sig_reg <= SIG_RESET;
		end else if (wr_fire && !and_hit && !or_hit) begin
			case (i_paddr)
				ADDR_CFG0: cfg_reg[31:0] <= i_pwdata;
				ADDR_CFG1: cfg_reg[63:32] <= i_pwdata;
				ADDR_CFG2: cfg_reg[67:64] <= i_pwdata[3:0];
				ADDR_SIG0: sig_reg[31:0] <= i_pwdata;
				ADDR_SIG1: sig_reg[63:32] <= i_pwdata;
				ADDR_SIG2: sig_reg[71:64] <= i_pwdata[7:0];
				default: sig_reg <= sig_reg;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int k = 0; k < NUM_PT; k++) begin
				and_mem[k] <= '0;
			end
		end else if (wr_fire && and_hit) begin
			case (and_w)
				2'h0: and_mem[pt_idx][31:0] <= i_pwdata;
				2'h1: and_mem[pt_idx][63:32] <= i_pwdata;
				default: and_mem[pt_idx][77:64] <= i_pwdata[13:0];
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int k = 0; k < NUM_ST; k++) begin
				or_mem[k] <= '0;
			end
		end else if (wr_fire && or_hit) begin
			if (or_w) begin
				or_mem[st_idx][63:32] <= i_pwdata;
			end else begin
				or_mem[st_idx][31:0] <= i_pwdata;
			end
		end
	end

endmodule

// [mla_board.sv]
// Board model that resolves the ten two-way pins of the logic array.
module mla_board (
	input wire logic i_clk,
	input wire logic [9:0] i_drv,
	input wire logic [9:0] i_oe,
	input wire logic [9:0] i_ext,
	input wire logic [9:0] i_ext_en,
	output logic [9:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// ======
	// Pin resolution
	// A floating pin has no pull, so it shows the inverse of its last level, never a held value.
	logic [9:0] last_pin;
	always_ff @(posedge i_clk) begin
		last_pin <= o_pin;
	end
	always_comb begin
		for (int b = 0; b < 10; b++) begin
			o_pin[b] = i_oe[b] ? i_drv[b] : (i_ext_en[b] ? i_ext[b] : ~last_pin[b]);
		end
	end
endmodule

// [mla_core_checker.sv]
// Port assertions for the macrocell logic array.
module mla_core_checker
	import mla_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [9:0] i_ded_in,
	input wire logic [9:0] i_pin_in,
	input wire logic i_input_capture_clock,
	input wire logic i_output_register_clock,
	input wire logic [9:0] o_pin_out,
	input wire logic [9:0] o_pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ======
	// Quiet counter: pins may only move while some input has moved recently.
	logic [22:0] in_cat;
	logic [22:0] in_reg;
	logic [3:0] quiet_reg;
	logic setup;
	assign in_cat = {i_ded_in, i_pin_in, i_input_capture_clock, i_output_register_clock, i_psel};
	assign setup = i_psel && !i_penable;
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			in_reg <= 23'h0;
			quiet_reg <= 4'h0;
		end else begin
			in_reg <= in_cat;
			quiet_reg <= (in_cat != in_reg) ? 4'h0 : ((quiet_reg == 4'hF) ? 4'hF : quiet_reg + 4'h1);
		end
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	// ======
	// Assertions
	a_ready_after_setup: assert property (setup |=> o_pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside access");
	a_err_with_ready: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	a_misaligned_err: assert property (setup && i_paddr[1:0] != 2'h0 |=> o_pslverr)
		else $error("misaligned access not refused");
	a_unmapped_err: assert property (setup && i_paddr == 12'h020 |=> o_pslverr)
		else $error("unmapped access not refused");
	a_err_read_zero: assert property (o_pready && o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
		else $error("refused read not zero");
	a_stat_no_err: assert property (setup && i_paddr == ADDR_STAT0 |=> !o_pslverr)
		else $error("status access refused");
	a_prdata_hold: assert property (!i_psel && $past(i_psel) == 1'b0 |-> $stable(o_prdata))
		else $error("read data moved while idle");
	a_pins_settle: assert property (quiet_reg >= 4'hC |->
		$stable(o_pin_oe) && $stable(o_pin_out))
		else $error("pin moved with quiet inputs");
	c_refused: cover property (o_pready && o_pslverr);
	c_pin_enabled: cover property ($rose(o_pin_oe[0]));
	c_pin_low: cover property ($fell(o_pin_out[0]));
endmodule
bind mla_core mla_core_checker u_chk (.*);

// [tb.sv]
// Self-checking bench for the macrocell logic array over APB and its pins.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mla_pkg::*;
	logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, ick = 0, ock = 0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h0, prd, rd;
	logic rdy, err, e;
	logic [9:0] ded = 10'h000, pin_in, pout, poe, ext = 10'h000, ext_en = 10'h3FF;
	int n_fail = 0, comparisons = 0;
	mla_core i_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
		.o_pslverr(err), .i_ded_in(ded), .i_input_capture_clock(ick),
		.i_output_register_clock(ock), .i_pin_in(pin_in), .o_pin_out(pout), .o_pin_oe(poe));
	mla_board i_brd (.i_clk(clk), .i_drv(pout), .i_oe(poe), .i_ext(ext), .i_ext_en(ext_en),
		.o_pin(pin_in));
	initial begin
		forever #2 clk = ~clk;
	end
	// ======
	// Tasks
	task end_of_test;
		if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the request stands until ready is sampled high.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1);
		chk(n, 32'h1);
		rd = prd;
		e = err;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	// Input pins pass synchronisers and a filter, so effects settle within a dozen cycles.
	task wt;
		repeat (12) @(posedge clk);
	endtask
	task tick;
		ock <= 1'b1;
		wt();
		ock <= 1'b0;
		wt();
	endtask
	// ======
	// Tests
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		apb(0, ADDR_CFG0, 32'h0);
		chk(rd, CFG_RESET[31:0]);
		apb(0, ADDR_CFG1, 32'h0);
		chk(rd, CFG_RESET[63:32]);
		apb(0, ADDR_CFG2, 32'h0);
		chk(rd, {28'h0, CFG_RESET[67:64]});
		apb(1, ADDR_SIG2, 32'hA5);
		apb(0, ADDR_SIG2, 32'h0);
		chk(rd, 32'hA5);
		apb(1, 12'h020, 32'h1);
		chk({31'h0, e}, 32'h1);
		apb(0, ADDR_STAT0, 32'h0);
		chk({31'h0, e}, 32'h0);
		chk({poe, pout}, {10'h000, 10'h3FF});
		apb(1, 12'h800, 32'h1);
		apb(1, 12'h810, 32'h10);
		apb(1, 12'hC00, 32'h40);
		apb(1, 12'hC10, 32'h4);
		apb(1, 12'h440, 32'h1);
		apb(1, 12'h4D0, 32'h2);
		ded <= 10'h003;
		wt();
		chk(poe[0], 1'b1);
		chk(pout[0], 1'b0);
		apb(1, ADDR_CFG0, CFG_RESET[31:0] | 32'h1);
		wt();
		chk(pout[0], 1'b1);
		apb(1, ADDR_CFG0, CFG_RESET[31:0]);
		ded <= 10'h001;
		wt();
		chk(poe[0], 1'b0);
		ded <= 10'h003;
		// The cell holds one when it turns registered, so a hold and a load can be told apart.
		apb(1, ADDR_CFG1, 32'hFFBF_C010);
		ded <= 10'h002;
		tick();
		chk(pout[0], 1'b0);
		ded <= 10'h006;
		tick();
		chk(pout[0], 1'b1);
		ded <= 10'h003;
		tick();
		chk(pout[0], 1'b1);
		ded <= 10'h007;
		tick();
		chk(pout[0], 1'b0);
		ded <= 10'h00B;
		wt();
		chk(pout[0], 1'b1);
		ded <= 10'h003;
		apb(1, ADDR_CFG1, 32'hFFBF_C000);
		wt();
		chk(pout[0], 1'b1);
		ded <= 10'h007;
		wt();
		chk(pout[0], 1'b0);
		apb(1, ADDR_CFG0, CFG_RESET[31:0] | 32'h4_0000);
		ded <= 10'h006;
		wt();
		chk(pout[0], 1'b0);
		ded <= 10'h002;
		wt();
		chk(pout[0], 1'b1);
		// Dedicated section registered: nothing captured yet, then one capture clock rise.
		apb(1, ADDR_CFG2, 32'hD);
		apb(0, ADDR_STAT1, 32'h0);
		chk(rd[19:10], 10'h000);
		ick <= 1'b1;
		wt();
		apb(0, ADDR_STAT1, 32'h0);
		chk(rd[19:10], 10'h002);
		ded <= 10'h005;
		wt();
		apb(0, ADDR_STAT1, 32'h0);
		chk(rd[19:10], 10'h002);
		apb(1, ADDR_CFG2, 32'hC);
		apb(0, ADDR_STAT1, 32'h0);
		chk(rd[19:10], 10'h005);
		ick <= 1'b0;
		wt();
		ded <= 10'h00A;
		wt();
		apb(0, ADDR_STAT1, 32'h0);
		chk(rd[19:10], 10'h005);
		apb(1, ADDR_CFG2, 32'hF);
		apb(0, ADDR_STAT1, 32'h0);
		chk(rd[19:10], 10'h00A);
		end_of_test();
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
endmodule
